// ==== rtl/fpr_host.sv ====
// Host read controller driving a byte-wide fuse PROM
module fpr_host
  import fpr_pkg::*;
(
  input wire logic mclk, // Clock, 40 MHz
  input wire logic arst_n, // Async reset, active low
  input wire fpr_part_t part, // Attached part and range
  input wire fpr_grade_t grade, // Large part speed grade
  input wire logic oc_mode, // High when part has open-collector data
  input wire logic rd_valid, // Read request
  input wire logic [fpr_pkg::FPR_HOST_AW-1:0] rd_addr, // Byte address
  output logic rd_ready, // Request accepted
  output logic [fpr_pkg::FPR_DW-1:0] rd_data, // Read data
  output logic rd_done, // One-cycle pulse with rd_data
  output logic [fpr_pkg::FPR_LARGE_AW-1:0] prom_addr, // Address pins
  output logic prom_sel1_n, // Select, active low
  output logic prom_sel2, // Select, active high (small part)
  output logic prom_sel3, // Select, active high (small part)
  input wire logic [fpr_pkg::FPR_DW-1:0] prom_data // Data pins as resolved
);
  // ==========================================================
  // Timing table
  localparam logic [FPR_CNT_W-1:0] SMALL_COM_CY =
    FPR_CNT_W'(fpr_cycles(FPR_SMALL_AA_COM_NS));
  localparam logic [FPR_CNT_W-1:0] SMALL_MIL_CY =
    FPR_CNT_W'(fpr_cycles(FPR_SMALL_AA_MIL_NS));
  localparam logic [FPR_CNT_W-1:0] LFC_CY =
    FPR_CNT_W'(fpr_cycles(FPR_LARGE_AA_FAST_COM_NS));
  localparam logic [FPR_CNT_W-1:0] LSC_CY =
    FPR_CNT_W'(fpr_cycles(FPR_LARGE_AA_STD_COM_NS));
  localparam logic [FPR_CNT_W-1:0] LFM_CY =
    FPR_CNT_W'(fpr_cycles(FPR_LARGE_AA_FAST_MIL_NS));
  localparam logic [FPR_CNT_W-1:0] LSM_CY =
    FPR_CNT_W'(fpr_cycles(FPR_LARGE_AA_STD_MIL_NS));
  // Select access is shorter than address access, and both are
  // started together, so address access governs the wait.
  localparam logic [FPR_CNT_W-1:0] SEL_SMALL_CY =
    FPR_CNT_W'(fpr_cycles(FPR_SMALL_CS_NS));
  localparam logic [FPR_CNT_W-1:0] SEL_LARGE_CY =
    FPR_CNT_W'(fpr_cycles(FPR_LARGE_CS_STD_MIL_NS));

  function automatic logic [FPR_CNT_W-1:0] max_cy(
    input logic [FPR_CNT_W-1:0] a,
    input logic [FPR_CNT_W-1:0] b
  );
    return (a > b) ? a : b;
  endfunction : max_cy

  fpr_state_t state_reg, state_next;
  logic [FPR_LARGE_AW-1:0] addr_reg, addr_next;
  logic sel_reg, sel_next;
  logic hit_reg, hit_next;
  logic [FPR_DW-1:0] data_reg, data_next;
  logic done_reg, done_next;
  logic [FPR_CNT_W-1:0] wait_cy;
  logic is_small;
  logic in_range;
  logic load;
  logic expired;

  assign is_small = (part == FPR_SMALL_COM) || (part == FPR_SMALL_MIL);

  // ==========================================================
  // Wait length per part
  always_comb begin
    unique case (part)
      FPR_SMALL_COM: wait_cy = max_cy(SMALL_COM_CY, SEL_SMALL_CY);
      FPR_SMALL_MIL: wait_cy = max_cy(SMALL_MIL_CY, SEL_SMALL_CY);
      FPR_LARGE_COM: wait_cy = max_cy((grade == FPR_FAST) ? LFC_CY : LSC_CY,
                                      SEL_LARGE_CY);
      FPR_LARGE_MIL: wait_cy = max_cy((grade == FPR_FAST) ? LFM_CY : LSM_CY,
                                      SEL_LARGE_CY);
    endcase
  end

  // Upper bits above the part's width must be zero for a hit
  always_comb begin
    if (is_small) begin
      in_range = (rd_addr >> FPR_SMALL_AW) == '0;
    end else begin
      in_range = (rd_addr >> FPR_LARGE_AW) == '0;
    end
  end

  fpr_wait_timer u_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .load(load),
    .cycles(wait_cy),
    .expired(expired)
  );

  // ==========================================================
  // Read sequencer
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    sel_next = sel_reg;
    hit_next = hit_reg;
    data_next = data_reg;
    done_next = 1'b0;
    load = 1'b0;
    unique case (state_reg)
      FPR_IDLE: begin
        if (rd_valid) begin
          // Address and select held stable for the whole access
          addr_next = rd_addr[FPR_LARGE_AW-1:0];
          if (is_small) begin
            addr_next[FPR_LARGE_AW-1:FPR_SMALL_AW] = '0;
          end
          hit_next = in_range;
          sel_next = in_range;
          load = 1'b1;
          state_next = FPR_WAIT;
        end
      end
      FPR_WAIT: begin
        if (expired) begin
          // Released pins read high, so a miss returns zero instead
          data_next = hit_reg ? prom_data : '0;
          done_next = 1'b1;
          sel_next = 1'b0;
          state_next = FPR_DONE;
        end
      end
      FPR_DONE: begin
        state_next = FPR_IDLE;
      end
      // Unused state code falls back to idle
      default: begin
        state_next = FPR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= FPR_IDLE;
      addr_reg <= '0;
      sel_reg <= 1'b0;
      hit_reg <= 1'b0;
      data_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      sel_reg <= sel_next;
      hit_reg <= hit_next;
      data_reg <= data_next;
      done_reg <= done_next;
    end
  end

  // ==========================================================
  // Pin drive
  assign prom_addr = addr_reg;
  assign prom_sel1_n = !sel_reg;
  assign prom_sel2 = sel_reg && is_small;
  assign prom_sel3 = sel_reg && is_small;
  assign rd_ready = (state_reg == FPR_IDLE);
  assign rd_data = data_reg;
  assign rd_done = done_reg;

  logic unused_oc;
  assign unused_oc = oc_mode;
endmodule : fpr_host

// ==== rtl/fpr_pkg.sv ====
// Constants and types shared by the fuse PROM read controller
package fpr_pkg;
  // ==========================================================
  // Part geometry
  localparam int FPR_SMALL_AW = 11;
  localparam int FPR_LARGE_AW = 13;
  localparam int FPR_DW = 8;
  localparam int FPR_HOST_AW = 17;
  // ==========================================================
  // Access times in ns, clock period in ps
  localparam int FPR_CLK_PS = 25000;
  localparam int FPR_SMALL_AA_COM_NS = 45;
  localparam int FPR_SMALL_AA_MIL_NS = 55;
  localparam int FPR_SMALL_CS_NS = 25;
  localparam int FPR_LARGE_AA_FAST_COM_NS = 45;
  localparam int FPR_LARGE_AA_STD_COM_NS = 55;
  localparam int FPR_LARGE_AA_FAST_MIL_NS = 55;
  localparam int FPR_LARGE_AA_STD_MIL_NS = 65;
  localparam int FPR_LARGE_CS_FAST_COM_NS = 25;
  localparam int FPR_LARGE_CS_STD_COM_NS = 30;
  localparam int FPR_LARGE_CS_FAST_MIL_NS = 30;
  localparam int FPR_LARGE_CS_STD_MIL_NS = 35;
  localparam int FPR_NS_PS = 1000;
  localparam int FPR_CNT_W = 4;
  // Minimum wait rounds up to whole clocks, at least one
  function automatic int fpr_cycles(input int ns);
    int c;
    c = (ns * FPR_NS_PS + FPR_CLK_PS - 1) / FPR_CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : fpr_cycles
  // ==========================================================
  // Part selection codes, sequencer states and counter constants
  typedef enum logic [1:0] {
    FPR_SMALL_COM,
    FPR_SMALL_MIL,
    FPR_LARGE_COM,
    FPR_LARGE_MIL
  } fpr_part_t;
  typedef enum logic {
    FPR_STD,
    FPR_FAST
  } fpr_grade_t;
  typedef enum logic [1:0] {
    FPR_IDLE,
    FPR_WAIT,
    FPR_DONE
  } fpr_state_t;
  localparam logic [FPR_CNT_W-1:0] FPR_CNT_ZERO = 4'h0;
  localparam logic [FPR_CNT_W-1:0] FPR_CNT_ONE = 4'h1;
endpackage : fpr_pkg

// ==== rtl/fpr_wait_timer.sv ====
// Down-counter that times the access wait
module fpr_wait_timer
  import fpr_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic arst_n, // Async reset
  input wire logic load, // Start the wait
  input wire logic [fpr_pkg::FPR_CNT_W-1:0] cycles, // Wait length
  output logic expired // High once the wait ran out
);
  logic [FPR_CNT_W-1:0] cnt_reg;
  logic [FPR_CNT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = cycles;
    end else if (cnt_reg != FPR_CNT_ZERO) begin
      cnt_next = cnt_reg - FPR_CNT_ONE;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= FPR_CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign expired = (cnt_reg == FPR_CNT_ZERO) && !load;
endmodule : fpr_wait_timer

// ==== testbench/fpr_host_sva.sv ====
// Pin-level checks for the fuse PROM read controller
module fpr_host_sva
  import fpr_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic arst_n, // Reset
  input wire fpr_pkg::fpr_part_t part, // Part
  input wire logic rd_valid, // Request
  input wire logic [fpr_pkg::FPR_HOST_AW-1:0] rd_addr, // Address
  input wire logic rd_ready, // Idle
  input wire logic rd_done, // Done
  input wire logic [fpr_pkg::FPR_LARGE_AW-1:0] prom_addr, // Pins
  input wire logic prom_sel1_n, // Select
  input wire logic prom_sel2, // Select
  input wire logic prom_sel3 // Select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire logic take = rd_valid && rd_ready;
  idle_desel_a: assert property (rd_ready |-> prom_sel1_n && !prom_sel2 && !prom_sel3)
    else $error("select while idle");
  small_sel_a: assert property (!part[1] && !prom_sel1_n |-> prom_sel2 && prom_sel3)
    else $error("small select");
  large_sel_a: assert property (part[1] |-> !prom_sel2 && !prom_sel3)
    else $error("large select");
  small_addr_a: assert property (!part[1] && !prom_sel1_n |-> prom_addr[12:11] == 2'h0)
    else $error("small address");
  take_addr_a: assert property (take && part[1] && rd_addr[16:13] == 4'h0 |=>
    !prom_sel1_n && prom_addr == $past(rd_addr[12:0])) else $error("address");
  sel_hold_a: assert property ($fell(prom_sel1_n) |=>
    (!prom_sel1_n && $stable(prom_addr)) [*2]) else $error("short access");
  done_lat_a: assert property (take |=> !rd_done [*3] ##[1:2] rd_done)
    else $error("latency");
  done_end_a: assert property (rd_done |-> prom_sel1_n ##1 !rd_done && rd_ready)
    else $error("done");
endmodule : fpr_host_sva
bind fpr_host fpr_host_sva u_fpr_host_sva(.mclk, .arst_n, .part, .rd_valid, .rd_addr,
  .rd_ready, .rd_done, .prom_addr, .prom_sel1_n, .prom_sel2, .prom_sel3);

// ==== testbench/fpr_prom_model.sv ====
// Behavioural fuse PROM as seen at its pins
module fpr_prom_model
  import fpr_pkg::*;
(
  input wire logic [fpr_pkg::FPR_LARGE_AW-1:0] prom_addr, // Address
  input wire logic prom_sel1_n, // Select
  input wire logic prom_sel2, // Select
  input wire logic prom_sel3, // Select
  input wire fpr_pkg::fpr_part_t part, // Part
  input wire fpr_pkg::fpr_grade_t grade, // Grade
  output logic [fpr_pkg::FPR_DW-1:0] prom_data // Resolved pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en;
  logic [12:0] a;
  logic [7:0] nxt;
  int dly;
  always_comb begin
    en = part[1] ? !prom_sel1_n : !prom_sel1_n && prom_sel2 && prom_sel3;
    a = part[1] ? prom_addr : {2'h0, prom_addr[10:0]};
    dly = part[1] ? (part[0]
      ? (grade == FPR_FAST ? FPR_LARGE_AA_FAST_MIL_NS : FPR_LARGE_AA_STD_MIL_NS)
      : (grade == FPR_FAST ? FPR_LARGE_AA_FAST_COM_NS : FPR_LARGE_AA_STD_COM_NS))
      : (part[0] ? FPR_SMALL_AA_MIL_NS : FPR_SMALL_AA_COM_NS);
    // Released pins float to the pull-up
    nxt = en ? a[7:0] ^ {3'h0, a[12:8]} : 8'hFF;
  end
  always @(nxt) begin
    prom_data = ~prom_data;
    prom_data <= #(dly) nxt;
  end
endmodule : fpr_prom_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the fuse PROM read controller
module testbench import fpr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  fpr_part_t part = FPR_SMALL_COM;
  fpr_grade_t grade = FPR_STD;
  logic oc_mode = 1'b0;
  logic rd_valid = 1'b0;
  logic [FPR_HOST_AW-1:0] rd_addr = '0;
  logic rd_ready, rd_done, prom_sel1_n, prom_sel2, prom_sel3;
  logic [FPR_DW-1:0] rd_data, prom_data;
  logic [FPR_LARGE_AW-1:0] prom_addr;
  logic [31:0] seed = 32'h13E1B452;
  int err_total = 0;
  int checks_done = 0;
  always #12.5 mclk = ~mclk;
  fpr_host u_fpr_host(.mclk, .arst_n, .part, .grade, .oc_mode, .rd_valid, .rd_addr,
    .rd_ready, .rd_data, .rd_done, .prom_addr, .prom_sel1_n, .prom_sel2, .prom_sel3, .prom_data);
  fpr_prom_model u_fpr_prom_model(.prom_addr, .prom_sel1_n, .prom_sel2, .prom_sel3, .part,
    .grade, .prom_data);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [7:0] exp_dat(input logic [16:0] a);
    if ((a >> (part[1] ? FPR_LARGE_AW : FPR_SMALL_AW)) != 0) return 8'h00;
    return a[7:0] ^ {3'h0, a[12:8]};
  endfunction : exp_dat
  // Edges from the taking edge through the edge that raises rd_done
  function automatic int exp_lat(input fpr_part_t p, input fpr_grade_t g);
    int aa;
    int cs;
    aa = FPR_SMALL_AA_COM_NS;
    cs = FPR_SMALL_CS_NS;
    case (p)
      FPR_SMALL_COM: aa = FPR_SMALL_AA_COM_NS;
      FPR_SMALL_MIL: aa = FPR_SMALL_AA_MIL_NS;
      FPR_LARGE_COM: begin
        aa = (g == FPR_FAST) ? FPR_LARGE_AA_FAST_COM_NS : FPR_LARGE_AA_STD_COM_NS;
        cs = (g == FPR_FAST) ? FPR_LARGE_CS_FAST_COM_NS : FPR_LARGE_CS_STD_COM_NS;
      end
      default: begin
        aa = (g == FPR_FAST) ? FPR_LARGE_AA_FAST_MIL_NS : FPR_LARGE_AA_STD_MIL_NS;
        cs = (g == FPR_FAST) ? FPR_LARGE_CS_FAST_MIL_NS : FPR_LARGE_CS_STD_MIL_NS;
      end
    endcase
    // Wait cycles, plus the take edge and the sampling edge
    return ((fpr_cycles(aa) > fpr_cycles(cs)) ? fpr_cycles(aa) : fpr_cycles(cs)) + 2;
  endfunction : exp_lat
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic rd(input logic [16:0] a);
    int n;
    rd_valid = 1'b1;
    rd_addr = a;
    n = 0;
    while (rd_ready !== 1'b1 && n < 9) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (rd_ready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      rd_valid = 1'b0;
      n++;
    end while (rd_done !== 1'b1 && n < 9);
    if (rd_done !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    chk("latency", exp_lat(part, grade), n);
    chk("rd_data", exp_dat(a), rd_data);
  endtask : rd
  initial begin
    logic [16:0] a;
    logic [16:0] m;
    repeat (12) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    for (int i = 0; i < 48; i++) begin
      part = fpr_part_t'(i / 12);
      grade = fpr_grade_t'(i / 6 % 2);
      seed = xs(seed);
      oc_mode = seed[31];
      m = part[1] ? 17'h01FFF : 17'h007FF;
      case (i % 6)
        0: a = 17'h00000;
        1: a = m;
        2: a = m + 17'h1;
        default: a = seed[16:0] & m;
      endcase
      rd(a);
    end
    // Reset in the middle of an access, then read again
    repeat (2) @(posedge mclk);
    #1;
    rd_valid = 1'b1;
    rd_addr = 17'h00123;
    @(posedge mclk);
    #1;
    rd_valid = 1'b0;
    chk("sel1_n", 1'b0, prom_sel1_n);
    arst_n = 1'b0;
    #1;
    chk("rst_sel1_n", 1'b1, prom_sel1_n);
    chk("rst_done", 1'b0, rd_done);
    chk("rst_ready", 1'b1, rd_ready);
    chk("rst_data", 8'h00, rd_data);
    repeat (2) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    rd(17'h00123);
    tally_and_finish();
  end
endmodule : testbench
